/* File: capcmp_channel.sv */
// one timer channel: input capture, output compare, pin ownership, apb registers
// assumes an apb master on clk; the pin pad merges pin_oe/pin_out with port logic
`timescale 1ns/1ps
`default_nettype none
`include "capcmp_regs.svh"

module capcmp_channel (
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic channel_pin_in,
	output logic channel_pin_out,
	output logic channel_pin_oe,
	output logic channel_pin_owned,
	output logic center_pwm_active,
	output logic channel_event_flag
);
	typedef struct packed {
		logic [1:0] clk_src;
		logic cas;
		logic [1:0] mode;
		logic [1:0] els;
		logic [15:0] value;
		logic [15:0] count;
		logic flag;
		logic pin_level;
		logic pin_oe;
		logic pin_owned;
		logic center;
		logic [31:0] rdata;
		logic ready;
		logic slverr;
	} chan_state_t;

	chan_state_t st_reg;
	chan_state_t st_next;
	logic [1:0] rst_sync_reg;
	logic rst_n;
	capcmp_pkg::chan_mode_t cur_mode;
	logic tick;
	logic match;
	logic capture_hit;
	logic access;
	logic mapped;

	pin_edge_if pe ();

	// reset release is synchronised so every flop leaves reset on the same edge
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	assign pe.pin_raw = channel_pin_in;

	pin_edge_sync u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.e(pe)
	);

	assign cur_mode = capcmp_pkg::decode_mode(st_reg.clk_src, st_reg.cas, st_reg.mode, st_reg.els);
	// every clock source advances on the bus clock here; no prescaler
	assign tick = (st_reg.clk_src != `CAPCMP_CLKSRC_OFF);
	assign match = tick && (st_reg.count == st_reg.value); // [R6]
	assign access = psel && penable && st_reg.ready;
	assign mapped = (paddr == `CAPCMP_CTRL_OFS) || (paddr == `CAPCMP_VALUE_OFS) ||
		(paddr == `CAPCMP_STATUS_OFS) || (paddr == `CAPCMP_COUNT_OFS);

	always_comb begin
		capture_hit = 1'b0;
		case (st_reg.els)
			`CAPCMP_ELS_RISE: capture_hit = pe.rise; // [R2]
			`CAPCMP_ELS_FALL: capture_hit = pe.fall; // [R2]
			`CAPCMP_ELS_BOTH: capture_hit = pe.rise | pe.fall; // [R2]
			default: capture_hit = 1'b0;
		endcase
		if (cur_mode != capcmp_pkg::CH_CAPTURE) begin
			capture_hit = 1'b0;
		end
	end

	always_comb begin
		st_next = st_reg;
		st_next.ready = psel && !penable;
		st_next.slverr = psel && !penable && !mapped;
		if (tick) begin
			st_next.count = st_reg.count + 16'h0001;
		end

		// apb writes first so that hardware events below take priority
		if (access && pwrite) begin
			case (paddr)
				`CAPCMP_CTRL_OFS: begin
					st_next.clk_src = pwdata[`CAPCMP_CTRL_CLKSRC_LSB +: 2];
					st_next.cas = pwdata[`CAPCMP_CTRL_CAS_BIT];
					st_next.mode = pwdata[`CAPCMP_CTRL_MODE_LSB +: 2];
					st_next.els = pwdata[`CAPCMP_CTRL_ELS_LSB +: 2];
				end
				`CAPCMP_VALUE_OFS: st_next.value = pwdata[15:0];
				`CAPCMP_STATUS_OFS: begin
					if (pwdata[`CAPCMP_STATUS_FLAG_BIT]) begin
						st_next.flag = 1'b0;
					end
				end
				default: st_next.flag = st_reg.flag;
			endcase
		end

		st_next.rdata = 32'h0000_0000;
		if (psel && !penable && !pwrite) begin
			case (paddr)
				`CAPCMP_CTRL_OFS: begin
					st_next.rdata[`CAPCMP_CTRL_CLKSRC_LSB +: 2] = st_reg.clk_src;
					st_next.rdata[`CAPCMP_CTRL_CAS_BIT] = st_reg.cas;
					st_next.rdata[`CAPCMP_CTRL_MODE_LSB +: 2] = st_reg.mode;
					st_next.rdata[`CAPCMP_CTRL_ELS_LSB +: 2] = st_reg.els;
				end
				`CAPCMP_VALUE_OFS: st_next.rdata[15:0] = st_reg.value;
				`CAPCMP_STATUS_OFS: begin
					st_next.rdata[`CAPCMP_STATUS_FLAG_BIT] = st_reg.flag;
					st_next.rdata[`CAPCMP_STATUS_PIN_BIT] = st_reg.pin_level;
					st_next.rdata[`CAPCMP_STATUS_OWNED_BIT] = st_reg.pin_owned;
					st_next.rdata[`CAPCMP_STATUS_CENTER_BIT] = st_reg.center;
				end
				`CAPCMP_COUNT_OFS: st_next.rdata[15:0] = st_reg.count;
				default: st_next.rdata = 32'h0000_0000;
			endcase
		end

		// capture beats a same-cycle value write and a same-cycle flag clear
		if (capture_hit) begin
			st_next.value = st_reg.count; // [R10]
			st_next.flag = 1'b1; // [R10]
		end

		case (cur_mode)
			capcmp_pkg::CH_RELEASED: begin
				st_next.pin_owned = 1'b0; // [R8]
				st_next.pin_oe = 1'b0; // [R8]
				st_next.center = 1'b0;
			end
			capcmp_pkg::CH_CAPTURE: begin
				st_next.pin_owned = 1'b1; // [R1] [R4]
				st_next.pin_oe = 1'b0; // [R4]
				st_next.center = 1'b0;
			end
			capcmp_pkg::CH_COMPARE: begin
				st_next.pin_owned = 1'b1; // [R5]
				st_next.pin_oe = 1'b1; // [R5]
				st_next.center = 1'b0;
				// toggle works from the held level, so the first toggle waits for a match
				if (match) begin
					st_next.flag = 1'b1;
					case (st_reg.els)
						`CAPCMP_ELS_TOGGLE: st_next.pin_level = ~st_reg.pin_level; // [R6] [R7]
						`CAPCMP_ELS_CLEAR: st_next.pin_level = 1'b0; // [R6]
						`CAPCMP_ELS_SET: st_next.pin_level = 1'b1; // [R6]
						default: st_next.pin_level = st_reg.pin_level;
					endcase
				end
			end
			capcmp_pkg::CH_CENTER_PWM: begin
				st_next.pin_owned = 1'b1; // [R9]
				st_next.pin_oe = 1'b1; // [R9]
				st_next.center = 1'b1; // [R9]
			end
			default: begin
				// edge-aligned pwm is out of scope: pin held at its last level
				st_next.pin_owned = 1'b1;
				st_next.pin_oe = 1'b1;
				st_next.center = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign prdata = st_reg.rdata;
	assign pready = st_reg.ready;
	assign pslverr = st_reg.slverr;
	assign channel_pin_out = st_reg.pin_level;
	assign channel_pin_oe = st_reg.pin_oe;
	assign channel_pin_owned = st_reg.pin_owned;
	assign center_pwm_active = st_reg.center;
	assign channel_event_flag = st_reg.flag;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	AST_CAPTURE_LATCH: assert property (capture_hit |=> // [R10]
		st_reg.flag && st_reg.value == $past(st_reg.count))
		else $error("capture edge did not latch the counter");
	AST_CAPTURE_EDGE_SEL: assert property ((cur_mode == capcmp_pkg::CH_CAPTURE && // [R2]
		st_reg.els == `CAPCMP_ELS_RISE && pe.fall) |-> !capture_hit)
		else $error("falling edge captured while rising edge selected");
	AST_RELEASE: assert property ((cur_mode == capcmp_pkg::CH_RELEASED && // [R8]
		$past(cur_mode) == capcmp_pkg::CH_RELEASED) |-> !channel_pin_owned && !channel_pin_oe)
		else $error("pin still held with edge field or clock source zero");
	AST_CAPTURE_INPUT: assert property ((cur_mode == capcmp_pkg::CH_CAPTURE && // [R4]
		$past(cur_mode) == capcmp_pkg::CH_CAPTURE) |-> channel_pin_owned && !channel_pin_oe)
		else $error("capture channel drives or releases its pin");
	AST_COMPARE_DRIVE: assert property ((cur_mode == capcmp_pkg::CH_COMPARE && // [R5]
		$past(cur_mode) == capcmp_pkg::CH_COMPARE) |-> channel_pin_owned && channel_pin_oe)
		else $error("compare channel does not drive its pin");
	AST_COMPARE_SET: assert property ((cur_mode == capcmp_pkg::CH_COMPARE && match && // [R6]
		st_reg.els == `CAPCMP_ELS_SET) |=> channel_pin_out)
		else $error("set on compare left pin low");
	AST_COMPARE_CLEAR: assert property ((cur_mode == capcmp_pkg::CH_COMPARE && match && // [R6]
		st_reg.els == `CAPCMP_ELS_CLEAR) |=> !channel_pin_out)
		else $error("clear on compare left pin high");
	AST_TOGGLE_HOLD: assert property ((cur_mode == capcmp_pkg::CH_COMPARE && !match && // [R7]
		st_reg.els == `CAPCMP_ELS_TOGGLE) |=> $stable(channel_pin_out))
		else $error("toggle mode changed pin without a match");
	AST_TOGGLE_FLIP: assert property ((cur_mode == capcmp_pkg::CH_COMPARE && match && // [R6]
		st_reg.els == `CAPCMP_ELS_TOGGLE) |=> channel_pin_out != $past(channel_pin_out))
		else $error("toggle on compare did not invert pin");
	AST_CENTER: assert property ((cur_mode == capcmp_pkg::CH_CENTER_PWM && // [R9]
		$past(cur_mode) == capcmp_pkg::CH_CENTER_PWM) |-> center_pwm_active && channel_pin_owned)
		else $error("center select did not take over the channel");

endmodule : capcmp_channel

`default_nettype wire

/* File: capcmp_regs.svh */
// register map, field positions, reset values and timing counts of the capture/compare channel
// assumes a 32-bit apb register port; included by the types package and the channel
//
// Function
// R1: capture mode when cas 0, mode 00, edge field nonzero
// R2: edge field picks rising, falling or both edges
// R3: pin synchronised to bus clock, four-clock pulses seen
// R4: capture overrides port data and direction of pin
// R5: compare mode when cas 0, mode 01, edge field nonzero
// R6: compare match toggles, clears or sets the pin
// R7: first toggle selection keeps previous level until match
// R8: pin released when edge field or clock source zero
// R9: center select with edge field nonzero means center pwm
// R10: capture edge latches counter and sets event flag
`ifndef CAPCMP_REGS_SVH
`define CAPCMP_REGS_SVH

`define CAPCMP_CTRL_OFS 12'h000
`define CAPCMP_VALUE_OFS 12'h004
`define CAPCMP_STATUS_OFS 12'h008
`define CAPCMP_COUNT_OFS 12'h00c

`define CAPCMP_CTRL_CLKSRC_LSB 0
`define CAPCMP_CTRL_CAS_BIT 2
`define CAPCMP_CTRL_MODE_LSB 4
`define CAPCMP_CTRL_ELS_LSB 6

`define CAPCMP_STATUS_FLAG_BIT 0
`define CAPCMP_STATUS_PIN_BIT 1
`define CAPCMP_STATUS_OWNED_BIT 2
`define CAPCMP_STATUS_CENTER_BIT 3

`define CAPCMP_MODE_CAPTURE 2'h0
`define CAPCMP_MODE_COMPARE 2'h1
`define CAPCMP_ELS_OFF 2'h0
`define CAPCMP_ELS_RISE 2'h1
`define CAPCMP_ELS_FALL 2'h2
`define CAPCMP_ELS_BOTH 2'h3
`define CAPCMP_ELS_TOGGLE 2'h1
`define CAPCMP_ELS_CLEAR 2'h2
`define CAPCMP_ELS_SET 2'h3
`define CAPCMP_CLKSRC_OFF 2'h0

`define CAPCMP_VALUE_RESET 16'h0000
`define CAPCMP_COUNT_RESET 16'h0000
`define CAPCMP_MIN_PULSE_CLOCKS 4
`define CAPCMP_SYNC_STAGES 2

`endif

/* File: capcmp_pkg.sv */
// types and mode decode of the capture/compare channel
// assumes the constants header sits beside it
`default_nettype none
`include "capcmp_regs.svh"

package capcmp_pkg;

	typedef enum logic [2:0] {
		CH_RELEASED,
		CH_CAPTURE,
		CH_COMPARE,
		CH_EDGE_PWM,
		CH_CENTER_PWM
	} chan_mode_t;

	function automatic chan_mode_t decode_mode(input logic [1:0] clk_src, input logic cas,
		input logic [1:0] mode, input logic [1:0] els);
		chan_mode_t m;
		m = CH_EDGE_PWM;
		if (els == `CAPCMP_ELS_OFF || clk_src == `CAPCMP_CLKSRC_OFF) begin
			m = CH_RELEASED;
		end else if (cas) begin
			m = CH_CENTER_PWM;
		end else if (mode == `CAPCMP_MODE_CAPTURE) begin
			m = CH_CAPTURE;
		end else if (mode == `CAPCMP_MODE_COMPARE) begin
			m = CH_COMPARE;
		end
		return m;
	endfunction : decode_mode

endpackage : capcmp_pkg

`default_nettype wire

/* File: pin_edge_if.sv */
// synchronised pin level and edge pulses passed from the edge detector to the channel
// assumes both ends share clk
`timescale 1ns/1ps
`default_nettype none

interface pin_edge_if;
	logic pin_raw;
	logic level;
	logic rise;
	logic fall;

	modport det (input pin_raw, output level, output rise, output fall);
	modport chan (output pin_raw, input level, input rise, input fall);
endinterface : pin_edge_if

`default_nettype wire

/* File: pin_edge_sync.sv */
// two-flop synchroniser and edge detector for the channel pin
// assumes pin_raw is asynchronous to clk; rst_n is already synchronised
`timescale 1ns/1ps
`default_nettype none

module pin_edge_sync (
	input wire logic clk,
	input wire logic rst_n,
	pin_edge_if.det e
);
	typedef struct packed {
		logic meta;
		logic sync;
		logic last;
		logic [2:0] fill;
	} sync_state_t;

	sync_state_t st_reg;
	sync_state_t st_next;

	// meta only feeds sync; edges compare the two settled stages
	always_comb begin
		st_next = st_reg;
		st_next.meta = e.pin_raw; // [R3]
		st_next.sync = st_reg.meta;
		st_next.last = st_reg.sync;
		st_next.fill = {st_reg.fill[1:0], 1'b1};
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign e.level = st_reg.sync;
	// edges masked until last holds a real sample: a pin idling high gives no false edge
	assign e.rise = st_reg.sync & ~st_reg.last & st_reg.fill[2];
	assign e.fall = ~st_reg.sync & st_reg.last & st_reg.fill[2];

	AST_SYNC_RISE: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
		e.rise |-> $past(e.pin_raw, 2) && !$past(e.pin_raw, 3))
		else $error("rise pulse without a synchronised low-high pin edge");
	AST_SYNC_FALL: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
		e.fall |-> !$past(e.pin_raw, 2) && $past(e.pin_raw, 3))
		else $error("fall pulse without a synchronised high-low pin edge");

endmodule : pin_edge_sync

`default_nettype wire

/* File: pin_partner.sv */
// pad and outside world of the channel pin: a level source plus the pad merge
// assumes the bench sets drive_lvl after a rising edge and holds each level >= 4 clocks
`timescale 1ns/1ps
`default_nettype none

module pin_partner (
	input wire logic drive_lvl,
	input wire logic pin_out,
	input wire logic pin_oe,
	output logic pin_in
);
	// pad shows the channel's level while it drives, else the outside source
	assign pin_in = pin_oe ? pin_out : drive_lvl;
endmodule : pin_partner

`default_nettype wire

/* File: tb_top.sv */
// self-checking bench of the capture/compare channel: config table, capture, compare, reset
// assumes pin_partner beside it and an apb slave with a one-cycle answer
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, src = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd, v1;
	logic pready, pslverr, pin_in, pin_out, pin_oe, owned, center, flag, err;
	int error_cnt = 0, comparisons = 0, cyc = 0, t0, n;
	// ctrl byte, then expected owned, oe, center
	logic [10:0] rows [8] = '{{8'h41, 3'b100}, {8'hc1, 3'b100}, {8'h51, 3'b110},
		{8'h11, 3'b000}, {8'h50, 3'b000}, {8'h45, 3'b111}, {8'h05, 3'b000},
		{8'h61, 3'b110}};
	logic [1:0] cels [4] = '{2'h3, 2'h2, 2'h3, 2'h1};
	logic cexp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

	capcmp_channel dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .channel_pin_in(pin_in), .channel_pin_out(pin_out),
		.channel_pin_oe(pin_oe), .channel_pin_owned(owned), .center_pwm_active(center),
		.channel_event_flag(flag));
	pin_partner pad (.drive_lvl(src), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

	initial begin
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
	end

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	// entered just after a rising edge; idles one cycle after release
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1);
		chk("pready_wait", k, 1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask : apb

	task automatic wrap_up;
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up

	initial begin
		#400000;
		error_cnt++;
		wrap_up();
	end

	initial begin
		repeat (5) @(posedge clk);
		nrst <= 1;
		repeat (3) @(posedge clk);
		chk("reset_ports", {pin_out, pin_oe, owned, center, flag}, 0);
		for (int a = 0; a < 16; a += 4) begin
			apb(0, a[11:0], 0);
			chk("reset_reg", rd, 0);
		end
		apb(0, 12'h010, 0);
		chk("unmapped_err", err, 1);
		foreach (rows[i]) begin
			apb(1, 12'h000, {24'h0, rows[i][10:3]});
			apb(0, 12'h008, 0);
			chk("cfg_ports", {owned, pin_oe, center}, rows[i][2:0]);
			chk("cfg_status", {rd[2], rd[3]}, {rows[i][2], rows[i][0]});
		end
		// capture: rising, falling, both; each level held well over four clocks
		for (int e = 1; e < 4; e++) begin
			apb(1, 12'h000, {24'h0, e[1:0], 6'h01});
			apb(1, 12'h008, 32'h1);
			src <= 1;
			t0 = cyc;
			repeat (5) @(posedge clk);
			chk("rise_flag", flag, e[0]);
			apb(0, 12'h004, 0);
			v1 = rd;
			apb(1, 12'h008, 32'h1);
			src <= 0;
			t0 = cyc - t0;
			repeat (5) @(posedge clk);
			chk("fall_flag", flag, e[1]);
			apb(0, 12'h004, 0);
			if (e == 3)
				chk("capture_gap", 16'(rd[15:0] - v1[15:0]), t0[15:0]);
		end
		// compare: set, clear, set, then toggle must hold until the match
		for (int i = 0; i < 4; i++) begin
			apb(0, 12'h00c, 0);
			apb(1, 12'h004, rd + 32'd30);
			apb(1, 12'h000, {24'h0, cels[i], 6'h11});
			chk("hold_pin", pin_out, !cexp[i]);
			n = 0;
			while (pin_out !== cexp[i] && n < 60) begin
				@(posedge clk);
				n++;
			end
			chk("match_pin", pin_out, cexp[i]);
		end
		chk("match_flag", flag, 1);
		// reset in mid-run drops the pin and the config
		nrst <= 0;
		repeat (2) @(posedge clk);
		chk("midreset_ports", {pin_out, pin_oe, owned, flag}, 0);
		nrst <= 1;
		repeat (3) @(posedge clk);
		apb(0, 12'h000, 0);
		chk("midreset_ctrl", rd, 0);
		wrap_up();
	end
endmodule : tb_top

`default_nettype wire
